/* edge_filter_defines.svh */
// Constants for the pin edge noise filter: reset values, field positions and timing counts
// Overview of operation
// - Reset clears the sample clock select register to zero.
// - Sample clock select register is written and read only as a whole byte.
// - Analog-filtered pins ignore pulses shorter than about 10 us.
// - Analog-filtered pins report an edge 10 us plus one to two system clocks after the pin.
// - Capture pin is sampled with the selected filter sampling clock.
// - Digital filter accepts a new level only after four equal samples.
// - Capture pin edge appears three to four sampling periods plus two system clocks after the pin.
// - Timer pins use the same four-sample filter on the system clock.
// - Timer pin edge appears five to six system clocks after the pin.
// - Edges arriving while polarity is rewritten are not guaranteed to be detected.
// - Noise synchronous to the sampling clock may pass; boards add filters.
// - Two polarity registers select rising or falling per pin; reset clears both.
// - Stop and idle halt detection except on the three analog-filtered pins.
`ifndef EDGE_FILTER_DEFINES_SVH
`define EDGE_FILTER_DEFINES_SVH

// Register reset values
`define SAMPLE_SEL_RESET 8'h00
`define POL_LOW_RESET    8'h00
`define POL_HIGH_RESET   8'h00

// Field positions
`define SAMPLE_RATE_LSB  0
`define SAMPLE_RATE_MSB  1
`define POL_LOW_PINS     4
`define POL_HIGH_PINS    3

// Sampling clock divide masks for the four rate codes
`define RATE_MASK_DIV1   6'h00
`define RATE_MASK_DIV4   6'h03
`define RATE_MASK_DIV16  6'h0f
`define RATE_MASK_DIV64  6'h3f

// Timing
`define DIGITAL_SAMPLES  4
`define CLK_PERIOD_NS    50
`define ANALOG_TIME_NS   10000
`define ANALOG_CYCLES    ((`ANALOG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* edge_filter_pkg.sv */
// Types shared by the pin edge noise filter
package edge_filter_pkg;

   // One bit per pin; bit 0 is the nonmaskable edge pin
   typedef struct packed {
      logic analogFilteredPinB;
      logic analogFilteredPinA;
      logic timerEdgePinC;
      logic timerEdgePinB;
      logic timerEdgePinA;
      logic digitallyFilteredCapturePin;
      logic nonmaskableEdgePin;
   } pinVec_t;

   // Sampling clock rate codes held in the select register
   typedef enum logic [1:0] {
      RATE_DIV1,
      RATE_DIV4,
      RATE_DIV16,
      RATE_DIV64
   } sampleRate_t;

endpackage

/* pin_edge_noise_filter.sv */
// Edge detection front end with analog-style and four-sample digital noise filters
`include "edge_filter_defines.svh"

module pin_edge_noise_filter
   import edge_filter_pkg::*;
#(
   parameter int ANALOG_CYC = `ANALOG_CYCLES
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // External pins, asynchronous
   input  wire pinVec_t    pinIn,
   // Byte-wide register writes from the CPU side
   input  wire logic       sampleSelWr,
   input  wire logic [7:0] sampleSelData,
   input  wire logic       polLowWr,
   input  wire logic [7:0] polLowData,
   input  wire logic       polHighWr,
   input  wire logic [7:0] polHighData,
   // Stop or idle standby active
   input  wire logic       standbyStop,
   // Register read back
   output logic [7:0]      sampleSelRd,
   output logic [7:0]      polLowRd,
   output logic [7:0]      polHighRd,
   // Filtered levels and one-cycle edge pulses
   output pinVec_t         filtLevel,
   output pinVec_t         edgeOut
);

   localparam int NPIN = 7;
   localparam int CW   = $clog2(ANALOG_CYC + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(ANALOG_CYC - 1);

   logic [7:0]      sampleSel_q;
   logic [7:0]      polLow_q;
   logic [7:0]      polHigh_q;
   logic [NPIN-1:0] pinMeta_q;
   logic [NPIN-1:0] pinSync_q;
   logic [NPIN-1:0] lvl_q;
   logic [NPIN-1:0] lvl_d;
   logic [NPIN-1:0] edge_q;
   logic [NPIN-1:0] edge_d;
   logic [NPIN-1:0] analogHit;
   logic [5:0]      divCnt_q;
   logic [5:0]      rateMask;
   logic [NPIN-1:0] pol;
   logic [NPIN-1:0] tick;
   logic            sampleTick;
   logic            polWrite;
   sampleRate_t     rate;

   // Registers: whole-byte writes only, so there is no bit-level strobe
   // Bits beyond the used fields are kept only for read back
   // byte registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sampleSel_q <= `SAMPLE_SEL_RESET;
         polLow_q    <= `POL_LOW_RESET;
         polHigh_q   <= `POL_HIGH_RESET;
      end else begin
         if (sampleSelWr) sampleSel_q <= sampleSelData;
         if (polLowWr)    polLow_q    <= polLowData;
         if (polHighWr)   polHigh_q   <= polHighData;
      end
   end

   assign sampleSelRd = sampleSel_q;
   assign polLowRd    = polLow_q;
   assign polHighRd   = polHigh_q;

   // Polarity per pin, 1 = rising; low register covers pins 0..3
   assign pol      = {polHigh_q[`POL_HIGH_PINS-1:0], polLow_q[`POL_LOW_PINS-1:0]};
   // Edges in a polarity write cycle are dropped, not judged against a changing polarity
   // polarity change window
   assign polWrite = polLowWr | polHighWr;

   // Two-stage synchroniser; only the second stage feeds logic
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pinMeta_q <= '0;
         pinSync_q <= '0;
      end else begin
         pinMeta_q <= pinIn;
         pinSync_q <= pinMeta_q;
      end
   end

   // Sampling clock enable from a free-running divider
   // The divider never stops, so a new rate code applies within one divider period
   // selectable sampling clock
   assign rate       = sampleRate_t'(sampleSel_q[`SAMPLE_RATE_MSB:`SAMPLE_RATE_LSB]);
   assign rateMask   = (rate == RATE_DIV1)  ? `RATE_MASK_DIV1  :
                       (rate == RATE_DIV4)  ? `RATE_MASK_DIV4  :
                       (rate == RATE_DIV16) ? `RATE_MASK_DIV16 : `RATE_MASK_DIV64;
   assign sampleTick = ((divCnt_q & rateMask) == 6'h00);

   always_ff @(posedge clk) begin
      if (!rst_b) divCnt_q <= 6'h00;
      else        divCnt_q <= divCnt_q + 6'h01;
   end

   // Per-pin tick: capture pin on the selected clock, timer pins every system clock
   // Analog bits are never read; they only keep the vector aligned with the pins
   // system and selected clock sampling
   assign tick = {2'b11, 3'b111, sampleTick, 1'b1};

   // Per-pin filters
   genvar i;
   generate
      for (i = 0; i < NPIN; i++) begin : g_pin
         if (i == 0 || i == 5 || i == 6) begin : g_analog
            // Delay filter: level must hold a full 10 us before it is taken.
            // Runs in standby too, since these pins wake the device.
            logic [CW-1:0] cnt_q;
            assign analogHit[i] = (cnt_q == CNT_LAST) && (pinSync_q[i] != lvl_q[i]);
            always_ff @(posedge clk) begin
               if (!rst_b)                     cnt_q <= '0;
               else if (pinSync_q[i] == lvl_q[i]) cnt_q <= '0;
               else if (analogHit[i])          cnt_q <= '0;
               else                            cnt_q <= cnt_q + CW'(1);
            end
            assign lvl_d[i] = analogHit[i] ? pinSync_q[i] : lvl_q[i];
         end else begin : g_digital
            // Three stored samples plus the current one make four in a row.
            // Noise locked to the sample clock can still slip through.
            // Standby freezes the history, so sampling resumes where it stopped.
            logic [`DIGITAL_SAMPLES-2:0] hist_q;
            logic                        run;
            logic                        agree;
            assign run   = tick[i] & ~standbyStop;
            assign agree = (hist_q == {(`DIGITAL_SAMPLES-1){pinSync_q[i]}});
            assign analogHit[i] = 1'b0;
            always_ff @(posedge clk) begin
               if (!rst_b)   hist_q <= '0;
               else if (run) hist_q <= {hist_q[`DIGITAL_SAMPLES-3:0], pinSync_q[i]};
            end
            assign lvl_d[i] = (run && agree) ? pinSync_q[i] : lvl_q[i];
         end
         assign edge_d[i] = (lvl_d[i] != lvl_q[i]) && (lvl_d[i] == pol[i]) && !polWrite;
      end
   endgenerate

   // Filtered levels and edge pulses, registered for clean outputs
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lvl_q  <= '0;
         edge_q <= '0;
      end else begin
         lvl_q  <= lvl_d;
         edge_q <= edge_d;
      end
   end

   assign filtLevel = pinVec_t'(lvl_q);
   assign edgeOut   = pinVec_t'(edge_q);

   // Checks
   // All assertions run on the system clock; all but the reset check rest while reset is held
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Four cycles of disagreement with a steady level and no standby on timer pin B;
   // a level that has just moved still holds older samples in its history
   sequence sTimerDiffer;
      (pinSync_q[3] != lvl_q[3] && $stable(lvl_q[3]) && !standbyStop)[*4];
   endsequence

   // Polarity register written
   sequence sPolWrite;
      polLowWr || polHighWr;
   endsequence

   property pResetClears;
      @(posedge clk) disable iff (1'b0)
      !rst_b |=> (sampleSelRd == 8'h00) && (polLowRd == 8'h00) && (polHighRd == 8'h00);
   endproperty

   AST_RESET_CLEARS: assert property (pResetClears)
      else $error("registers not cleared by reset");

   AST_SEL_WRITE: assert property (sampleSelWr |=> sampleSelRd == $past(sampleSelData))
      else $error("select register byte write lost");

   AST_POL_WRITE: assert property (polLowWr |=> polLowRd == $past(polLowData))
      else $error("polarity register byte write lost");

   AST_ANALOG_HOLD: assert property ($changed(lvl_q[5]) |-> $past(analogHit[5]))
      else $error("analog pin level changed before hold time");

   AST_ANALOG_STANDBY: assert property
      (standbyStop && analogHit[0] |=> lvl_q[0] == $past(pinSync_q[0]))
      else $error("analog pin stopped in standby");

   AST_DIGITAL_FREEZE: assert property (standbyStop |=> lvl_q[4:1] == $past(lvl_q[4:1]))
      else $error("digital filter moved in standby");

   AST_TIMER_FOUR: assert property
      ($changed(lvl_q[2]) |-> $past(pinSync_q[2], 1) == lvl_q[2] &&
       $past(pinSync_q[2], 2) == lvl_q[2] && $past(pinSync_q[2], 3) == lvl_q[2] &&
       $past(pinSync_q[2], 4) == lvl_q[2])
      else $error("timer pin level taken before four samples");

   AST_TIMER_LATENCY: assert property (sTimerDiffer |=> lvl_q[3] == $past(pinSync_q[3]))
      else $error("timer pin level late");

   AST_CAPTURE_TICK: assert property ($changed(lvl_q[1]) |-> $past(sampleTick))
      else $error("capture level changed off the sampling clock");

   AST_POL_BLANK: assert property (sPolWrite |=> edge_q == '0)
      else $error("edge reported during polarity write");

   AST_EDGE_PULSE: assert property
      (edge_q[4] |-> lvl_q[4] != $past(lvl_q[4]) && lvl_q[4] == $past(pol[4]) ##1 !edge_q[4])
      else $error("edge pulse without matching transition");

endmodule

/* pin_source.sv */
// External signal source model driving the seven port pins
module pin_source
   import edge_filter_pkg::*;
(
   // Levels requested by the bench
   input  wire pinVec_t want,
   // Pin levels seen by the filter
   output wire pinVec_t pinOut
);
   timeunit 1ns;
   timeprecision 1ns;

   // levels held as long as commanded
   assign pinOut = want;
endmodule

/* pin_edge_noise_filter_test.sv */
// Self-checking bench for the pin edge noise filter
module pin_edge_noise_filter_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int AC = 8;
   localparam int LIMIT = 10000;
   logic       clk, rst_b, standbyStop;
   logic       sampleSelWr, polLowWr, polHighWr;
   logic [7:0] sampleSelData, polLowData, polHighData;
   logic [7:0] sampleSelRd, polLowRd, polHighRd;
   logic [6:0] want, pinIn, filtLevel, edgeOut, pol;
   int         cyc, rate, numErrors, checkCount;

   // Expected polarity kept from what the bench wrote
   assign pol = {polHighData[2:0], polLowData[3:0]};

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   pin_source i_pin_source (.want(want), .pinOut(pinIn));
   pin_edge_noise_filter #(.ANALOG_CYC(AC)) i_pin_edge_noise_filter (
      .clk(clk), .rst_b(rst_b), .pinIn(pinIn), .sampleSelWr(sampleSelWr),
      .sampleSelData(sampleSelData), .polLowWr(polLowWr), .polLowData(polLowData),
      .polHighWr(polHighWr), .polHighData(polHighData), .standbyStop(standbyStop),
      .sampleSelRd(sampleSelRd), .polLowRd(polLowRd), .polHighRd(polHighRd),
      .filtLevel(filtLevel), .edgeOut(edgeOut));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
      checkCount++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value at %0t ns: %s", $time, m);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard; a stuck wait still reaches the verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         numErrors++;
         results();
      end
   end

   // Byte write with a one-clock strobe; data stays as the model copy
   task automatic wr(input int k, input logic [7:0] d);
      @(negedge clk);
      if (k == 0) {sampleSelWr, sampleSelData} = {1'b1, d};
      if (k == 1) {polLowWr, polLowData} = {1'b1, d};
      if (k == 2) {polHighWr, polHighData} = {1'b1, d};
      @(negedge clk);
      {sampleSelWr, polLowWr, polHighWr} = 3'h0;
      chk(k == 0 ? sampleSelRd : k == 1 ? polLowRd : polHighRd, d, "read back");
   endtask

   // One pulse on a pin, then count pulses and measure latency
   task automatic run(input int pin, input bit long, input bit expd);
      int p, lo, hi, w, t0, tEdge, other;
      int hits[$];
      logic lvl;
      p = (pin == 1) ? 1 << (2 * rate) : 1;
      lo = 3 * p;
      hi = 4 * p + 2;
      // analog pins use the hold time
      if (pin == 0 || pin > 4) begin
         lo = AC;
         hi = AC + 3;
      end
      // short pulses give three samples at most, or AC - 2 cycles on analog pins
      w = long ? hi + p + int'($urandom_range(3)) : (lo == AC ? AC - 2 : 3 * p);
      lvl = ~want[pin];
      @(negedge clk);
      want[pin] = lvl;
      t0 = cyc;
      other = 0;
      tEdge = (lvl == pol[pin]) ? t0 : t0 + w;
      for (int i = 1; i <= w + hi + 3; i++) begin
         @(posedge clk);
         #1;
         if (edgeOut[pin] === 1'b1) hits.push_back(cyc);
         if ((edgeOut & ~(7'h01 << pin)) !== 7'h00) other++;
         if (i == w) begin
            @(negedge clk);
            want[pin] = ~lvl;
         end
      end
      chk(8'(hits.size()), 8'(expd), "pulse count");
      if (expd && hits.size() > 0)
         chk(8'(hits[0] - tEdge >= lo && hits[0] - tEdge <= hi), 8'h01, "latency");
      chk(8'(other), 8'h00, "stray pulse");
      chk({7'h00, filtLevel[pin]}, {7'h00, ~lvl}, "level");
      $display("test pin %0d width %0d done", pin, w);
   endtask

   initial begin
      {rst_b, standbyStop, sampleSelWr, polLowWr, polHighWr} = 5'h00;
      {sampleSelData, polLowData, polHighData} = 24'h000000;
      want = 7'h00;
      rate = 0;
      void'($urandom(78308));
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      chk(sampleSelRd, 8'h00, "select reset");
      chk(polLowRd | polHighRd, 8'h00, "polarity reset");
      // Second pass flips every polarity bit
      for (int pass = 0; pass < 2; pass++) begin
         wr(1, pass ? ~polLowData : 8'($urandom));
         wr(2, pass ? ~polHighData : 8'($urandom));
         for (int p = 0; p < 7; p++) begin
            if (p != 1) begin
               run(p, 1, 1);
               run(p, 0, 0);
            end
         end
         for (rate = 0; rate < 4; rate++) begin
            wr(0, {6'($urandom), rate[1:0]});
            run(1, 1, 1);
            run(1, 0, 0);
         end
      end
      rate = 0;
      wr(0, 8'h00);
      wr(1, polLowData | 8'h04);
      @(negedge clk);
      want[2] = 1'b1;
      repeat (5) @(negedge clk);
      polLowWr = 1'b1;
      @(negedge clk);
      polLowWr = 1'b0;
      chk({7'h00, edgeOut[2]}, 8'h00, "blanked edge");
      chk({7'h00, filtLevel[2]}, 8'h01, "blanked level");
      want[2] = 1'b0;
      repeat (8) @(negedge clk);
      chk({7'h00, filtLevel[2]}, 8'h00, "level after blank");
      $display("test polarity blank done");
      standbyStop = 1'b1;
      run(2, 1, 0);
      run(1, 1, 0);
      run(5, 1, 1);
      run(0, 1, 1);
      standbyStop = 1'b0;
      results();
   end
endmodule
